// ==== rtl/pesl_cfg.svh ====
`ifndef PESL_CFG_SVH
`define PESL_CFG_SVH

// register byte offsets on the slave port
`define PESL_OFF_CTRL 8'h00
`define PESL_OFF_LCNT 8'h04
`define PESL_OFF_UCNT 8'h08

// control register field positions and reset value
`define PESL_CTRL_LSEL_LSB 0
`define PESL_CTRL_USEL_LSB 8
`define PESL_CTRL_MODE_BIT 16
`define PESL_CTRL_RST 32'h0000_0000
`define PESL_CNT_RST 32'h0000_0000

// ahb transfer type bit that marks an active transfer
`define PESL_HTRANS_ACTIVE_BIT 1

// select codes handled by this block
`define PESL_L_REMOTE_WB 6'h19
`define PESL_L_LOCAL_MISS 6'h1A
`define PESL_L_TAG_RETRY 6'h1B
`define PESL_U_TAG_RETRY 6'h28
`define PESL_U_REMOTE_MISS 6'h29
`define PESL_L_SNOOP 6'h11
`define PESL_L_FLOW_PAUSE 6'h12
`define PESL_L_OWNED 6'h13
`define PESL_L_SW_MARKER 6'h14
`define PESL_U_SW_MARKER 6'h1C
`define PESL_L_FP_ADD 6'h18
`define PESL_U_FP_MUL 6'h27

// reserved select codes, one bit per code
`define PESL_L_RESERVED 64'hFFFF_FFC0_F000_0880
`define PESL_U_RESERVED 64'hFFFF_FC00_0080_0000

// marker instruction: set high part of the constant into the zero register
`define PESL_MARKER_IMM 20'hFC000
`define PESL_MARKER_WORD {2'h0, 5'h00, 3'h4, 22'(`PESL_MARKER_IMM >> 10)}

`endif

// ==== rtl/pesl_counter.sv ====
`timescale 1ns/1ns
`include "pesl_cfg.svh"
module pesl_counter (
	// clock and reset
	input logic sys_clk,
	input logic reset,
	// software load
	input logic load,
	input logic [31:0] load_value,
	// event strobe
	input logic inc,
	// count
	output logic [31:0] count
);
	logic [31:0] count_reg; // running count

	// a software load wins over an event in the same cycle
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			count_reg <= `PESL_CNT_RST;
		end else if (load) begin
			count_reg <= load_value;
		end else if (inc) begin
			count_reg <= count_reg + 32'h0000_0001;
		end
	end

	assign count = count_reg;

endmodule : pesl_counter

// ==== rtl/pesl_event_decode.sv ====
`timescale 1ns/1ns
module pesl_event_decode (
	// transaction descriptor
	input pesl_pkg::pesl_txn_t txn,
	// locality counting mode
	input logic clustered_shared_memory_mode,
	// decoded events
	output pesl_pkg::pesl_loc_ev_t loc_ev,
	output logic retry_req,
	output pesl_pkg::pesl_txn_kind_t retry_kind
);
	import pesl_pkg::*;

	logic plain_read; // share, own or stream read in its plain form
	logic remote_form; // any remote-form transaction
	logic bst_cause; // write stream caused by block store or commit

	// classify the transaction kind
	always_comb begin
		plain_read = (txn.kind == PESL_TXN_READ_SHARE) ||
			(txn.kind == PESL_TXN_READ_OWN) || (txn.kind == PESL_TXN_READ_STREAM);
		remote_form = (txn.kind == PESL_TXN_R_READ_SHARE) ||
			(txn.kind == PESL_TXN_R_READ_OWN) || (txn.kind == PESL_TXN_R_READ_STREAM) ||
			(txn.kind == PESL_TXN_R_WRITE_STREAM) || (txn.kind == PESL_TXN_R_WRITEBACK);
		bst_cause = txn.block_store_op || txn.block_store_commit_op;
	end

	// a plain read that meets an unexpected tag is retried, local region only
	assign retry_req = txn.valid && txn.local_phys_region && plain_read && txn.tag_unexpected;

	// the retry goes out in the remote form of the same read
	always_comb begin
		unique case (txn.kind)
			PESL_TXN_READ_SHARE: retry_kind = PESL_TXN_R_READ_SHARE;
			PESL_TXN_READ_OWN: retry_kind = PESL_TXN_R_READ_OWN;
			PESL_TXN_READ_STREAM: retry_kind = PESL_TXN_R_READ_STREAM;
			default: retry_kind = PESL_TXN_NONE;
		endcase
	end

	// the four locality sources; all held quiet outside the clustered mode
	always_comb begin
		loc_ev.local_region_miss_event = clustered_shared_memory_mode && txn.valid &&
			txn.local_phys_region && plain_read;
		loc_ev.tag_retry_event = clustered_shared_memory_mode && retry_req;
		loc_ev.remote_region_miss_event = clustered_shared_memory_mode && txn.valid && (
			(remote_form && !txn.local_phys_region) ||
			((txn.kind == PESL_TXN_R_WRITE_STREAM) && bst_cause) ||
			((txn.kind == PESL_TXN_R_READ_OWN) && txn.local_phys_region &&
			txn.store_owned_shared));
		loc_ev.remote_writeback_event = clustered_shared_memory_mode && txn.valid &&
			(txn.kind == PESL_TXN_R_WRITEBACK) && !txn.local_phys_region;
	end

endmodule : pesl_event_decode

// ==== rtl/pesl_pkg.sv ====
package pesl_pkg;

	// kind of system transaction issued by the core
	typedef enum logic [3:0] {
		PESL_TXN_NONE = 4'h0,
		PESL_TXN_READ_SHARE = 4'h1,
		PESL_TXN_READ_OWN = 4'h2,
		PESL_TXN_READ_STREAM = 4'h3,
		PESL_TXN_R_READ_SHARE = 4'h4,
		PESL_TXN_R_READ_OWN = 4'h5,
		PESL_TXN_R_READ_STREAM = 4'h6,
		PESL_TXN_R_WRITE_STREAM = 4'h7,
		PESL_TXN_R_WRITEBACK = 4'h8,
		PESL_TXN_WRITEBACK = 4'h9
	} pesl_txn_kind_t;

	// one transaction descriptor, valid for one cycle
	typedef struct packed {
		logic valid;
		logic local_phys_region;
		pesl_txn_kind_t kind;
		logic block_store_op;
		logic block_store_commit_op;
		logic store_owned_shared;
		logic tag_unexpected;
	} pesl_txn_t;

	// system interface, software and fp pipeline strobes
	typedef struct packed {
		logic remote_snoop;
		logic sys_clk_tick;
		logic flow_pause_out;
		logic bus_request;
		logic owned_in;
		logic fp_adder_done;
		logic fp_mult_done;
		logic instr_retire;
		logic [31:0] instr_word;
	} pesl_sys_ev_t;

	// decoded data locality events
	typedef struct packed {
		logic local_region_miss_event;
		logic tag_retry_event;
		logic remote_region_miss_event;
		logic remote_writeback_event;
	} pesl_loc_ev_t;

	// ahb-lite master to slave signals
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} pesl_ahb_req_t;

	// ahb-lite slave to master signals
	typedef struct packed {
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
	} pesl_ahb_rsp_t;

endpackage : pesl_pkg

// ==== rtl/pesl_top.sv ====
`timescale 1ns/1ns
`include "pesl_cfg.svh"
module pesl_top (
	// clock and reset
	input logic sys_clk,
	input logic reset,
	// ahb-lite slave port
	input pesl_pkg::pesl_ahb_req_t ahb_req,
	output pesl_pkg::pesl_ahb_rsp_t ahb_rsp,
	// event sources
	input pesl_pkg::pesl_txn_t txn,
	input pesl_pkg::pesl_sys_ev_t sys_ev,
	input logic [63:0] ext_lower_events,
	input logic [63:0] ext_upper_events,
	// retry reissue request
	output logic retry_issue_valid,
	output pesl_pkg::pesl_txn_kind_t retry_issue_kind,
	// counter values
	output logic [31:0] lower_event_counter,
	output logic [31:0] upper_event_counter
);
	import pesl_pkg::*;

	// bus decode
	logic addr_take; // address phase accepted this cycle
	logic wr_dp_reg; // write data phase pending
	logic [7:0] wr_off_reg; // offset of pending write
	logic [31:0] hrdata_reg; // read data for the data phase
	logic [31:0] rd_value; // value of addressed register
	logic ctrl_wr; // control register written now
	logic lcnt_wr; // lower counter loaded now
	logic ucnt_wr; // upper counter loaded now

	// control state
	logic [5:0] lower_event_select_reg;
	logic [5:0] upper_event_select_reg;
	logic ssm_mode_reg; // clustered_shared_memory_mode
	logic [31:0] ctrl_view; // control register as read
	logic [31:0] ctrl_next; // control register after this cycle

	// event paths
	pesl_loc_ev_t loc_ev;
	logic retry_req;
	pesl_txn_kind_t retry_kind;
	logic marker_hit; // marker instruction retired
	logic [63:0] lower_src; // event per lower code before masking
	logic [63:0] upper_src; // event per upper code before masking
	logic [63:0] lower_vec; // event per lower code, reserved removed
	logic [63:0] upper_vec; // event per upper code, reserved removed
	logic lower_inc;
	logic upper_inc;

	// retry output state
	logic retry_valid_reg;
	pesl_txn_kind_t retry_kind_reg;

	// accept an address phase on an active, selected, ready transfer
	assign addr_take = ahb_req.hsel && ahb_req.htrans[`PESL_HTRANS_ACTIVE_BIT] && ahb_req.hready;

	// zero wait state slave; every answer is okay
	always_comb begin
		ahb_rsp.hreadyout = 1'b1;
		ahb_rsp.hresp = 1'b0;
		ahb_rsp.hrdata = hrdata_reg;
	end

	// remember a write until its data arrives in the next cycle
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wr_dp_reg <= 1'b0;
			wr_off_reg <= 8'h00;
		end else begin
			wr_dp_reg <= addr_take && ahb_req.hwrite;
			wr_off_reg <= ahb_req.haddr[7:0];
		end
	end

	// write strobes in the data phase; other offsets are ignored
	assign ctrl_wr = wr_dp_reg && (wr_off_reg == `PESL_OFF_CTRL);
	assign lcnt_wr = wr_dp_reg && (wr_off_reg == `PESL_OFF_LCNT);
	assign ucnt_wr = wr_dp_reg && (wr_off_reg == `PESL_OFF_UCNT);

	// control view and its next value, unused bits read zero
	always_comb begin
		ctrl_view = `PESL_CTRL_RST;
		ctrl_view[`PESL_CTRL_LSEL_LSB +: 6] = lower_event_select_reg;
		ctrl_view[`PESL_CTRL_USEL_LSB +: 6] = upper_event_select_reg;
		ctrl_view[`PESL_CTRL_MODE_BIT] = ssm_mode_reg;
		ctrl_next = ctrl_view;
		if (ctrl_wr) begin
			ctrl_next = `PESL_CTRL_RST;
			ctrl_next[`PESL_CTRL_LSEL_LSB +: 6] = ahb_req.hwdata[`PESL_CTRL_LSEL_LSB +: 6];
			ctrl_next[`PESL_CTRL_USEL_LSB +: 6] = ahb_req.hwdata[`PESL_CTRL_USEL_LSB +: 6];
			ctrl_next[`PESL_CTRL_MODE_BIT] = ahb_req.hwdata[`PESL_CTRL_MODE_BIT];
		end
	end

	// control register; selects are independent fields
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			lower_event_select_reg <= 6'h00;
			upper_event_select_reg <= 6'h00;
			ssm_mode_reg <= 1'b0;
		end else if (ctrl_wr) begin
			lower_event_select_reg <= ctrl_next[`PESL_CTRL_LSEL_LSB +: 6];
			upper_event_select_reg <= ctrl_next[`PESL_CTRL_USEL_LSB +: 6];
			ssm_mode_reg <= ctrl_next[`PESL_CTRL_MODE_BIT];
		end
	end

	// read mux forwards a write landing in the same cycle, so a read
	// right behind a write sees the new value rather than a stale one
	always_comb begin
		unique case (ahb_req.haddr[7:0])
			`PESL_OFF_CTRL: rd_value = ctrl_next;
			`PESL_OFF_LCNT: rd_value = lcnt_wr ? ahb_req.hwdata : lower_event_counter;
			`PESL_OFF_UCNT: rd_value = ucnt_wr ? ahb_req.hwdata : upper_event_counter;
			default: rd_value = 32'h0000_0000; // unmapped reads zero
		endcase
	end

	// read data captured at the address phase, shown in the data phase
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (addr_take && !ahb_req.hwrite) begin
			hrdata_reg <= rd_value;
		end
	end

	// locality classification of the transaction stream
	pesl_event_decode u_decode (
		.txn(txn),
		.clustered_shared_memory_mode(ssm_mode_reg),
		.loc_ev(loc_ev),
		.retry_req(retry_req),
		.retry_kind(retry_kind)
	);

	// marker instruction: full word compare, so look-alikes with other
	// destinations or constants do not count
	assign marker_hit = sys_ev.instr_retire && (sys_ev.instr_word == `PESL_MARKER_WORD);

	// own events override the external vectors at their codes
	always_comb begin
		lower_src = ext_lower_events;
		upper_src = ext_upper_events;
		lower_src[`PESL_L_LOCAL_MISS] = loc_ev.local_region_miss_event;
		lower_src[`PESL_L_TAG_RETRY] = loc_ev.tag_retry_event;
		upper_src[`PESL_U_TAG_RETRY] = loc_ev.tag_retry_event;
		upper_src[`PESL_U_REMOTE_MISS] = loc_ev.remote_region_miss_event;
		lower_src[`PESL_L_REMOTE_WB] = loc_ev.remote_writeback_event;
		lower_src[`PESL_L_SNOOP] = sys_ev.remote_snoop;
		// counted in system clock cycles: one tick per system cycle
		lower_src[`PESL_L_FLOW_PAUSE] = sys_ev.flow_pause_out && sys_ev.sys_clk_tick;
		lower_src[`PESL_L_OWNED] = sys_ev.bus_request && sys_ev.owned_in;
		lower_src[`PESL_L_SW_MARKER] = marker_hit;
		upper_src[`PESL_U_SW_MARKER] = marker_hit;
		lower_src[`PESL_L_FP_ADD] = sys_ev.fp_adder_done;
		upper_src[`PESL_U_FP_MUL] = sys_ev.fp_mult_done;
	end

	// reserved codes are forced quiet, per code
	for (genvar i = 0; i < 64; i++) begin : g_mask
		localparam logic [63:0] LRES = `PESL_L_RESERVED;
		localparam logic [63:0] URES = `PESL_U_RESERVED;
		assign lower_vec[i] = lower_src[i] && !LRES[i];
		assign upper_vec[i] = upper_src[i] && !URES[i];
	end

	// each counter picks its own event
	assign lower_inc = lower_vec[lower_event_select_reg];
	assign upper_inc = upper_vec[upper_event_select_reg];

	// lower counter
	pesl_counter u_lower (
		.sys_clk(sys_clk),
		.reset(reset),
		.load(lcnt_wr),
		.load_value(ahb_req.hwdata),
		.inc(lower_inc),
		.count(lower_event_counter)
	);

	// upper counter
	pesl_counter u_upper (
		.sys_clk(sys_clk),
		.reset(reset),
		.load(ucnt_wr),
		.load_value(ahb_req.hwdata),
		.inc(upper_inc),
		.count(upper_event_counter)
	);

	// retry reissue strobe, one cycle after the offending transaction
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			retry_valid_reg <= 1'b0;
			retry_kind_reg <= PESL_TXN_NONE;
		end else begin
			retry_valid_reg <= retry_req;
			retry_kind_reg <= retry_req ? retry_kind : PESL_TXN_NONE;
		end
	end

	assign retry_issue_valid = retry_valid_reg;
	assign retry_issue_kind = retry_kind_reg;

	// checks on the counting paths
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	// plain read to the local region in clustered mode
	sequence s_local_read;
		ssm_mode_reg && txn.valid && txn.local_phys_region &&
			(txn.kind == PESL_TXN_READ_OWN || txn.kind == PESL_TXN_READ_SHARE ||
			txn.kind == PESL_TXN_READ_STREAM);
	endsequence

	// such a read also meeting an unexpected tag
	sequence s_tag_miss;
		s_local_read ##0 txn.tag_unexpected;
	endsequence

	// lower counter stepped by exactly one
	sequence s_lower_step;
		lower_event_counter == $past(lower_event_counter) + 32'h0000_0001;
	endsequence

	// upper counter stepped by exactly one
	sequence s_upper_step;
		upper_event_counter == $past(upper_event_counter) + 32'h0000_0001;
	endsequence

	a_local_miss_cnt: assert property (
		s_local_read ##0 (lower_event_select_reg == `PESL_L_LOCAL_MISS && !lcnt_wr)
		|=> s_lower_step)
		else $error("local miss not counted on lower");

	a_tag_retry_both: assert property (
		s_tag_miss ##0 (lower_event_select_reg == `PESL_L_TAG_RETRY &&
		upper_event_select_reg == `PESL_U_TAG_RETRY && !lcnt_wr && !ucnt_wr)
		|=> s_lower_step ##0 s_upper_step)
		else $error("tag retry not counted on both");

	a_remote_bst_cnt: assert property (
		ssm_mode_reg && txn.valid && txn.kind == PESL_TXN_R_WRITE_STREAM &&
		txn.block_store_commit_op && upper_event_select_reg == `PESL_U_REMOTE_MISS &&
		!ucnt_wr |=> s_upper_step)
		else $error("remote block store miss not counted");

	a_remote_wb_cnt: assert property (
		ssm_mode_reg && txn.valid && txn.kind == PESL_TXN_R_WRITEBACK &&
		!txn.local_phys_region && lower_event_select_reg == `PESL_L_REMOTE_WB &&
		!lcnt_wr |=> s_lower_step)
		else $error("remote writeback not counted");

	a_mode_gate: assert property (
		!ssm_mode_reg && lower_event_select_reg == `PESL_L_LOCAL_MISS && !lcnt_wr
		|=> $stable(lower_event_counter))
		else $error("locality event counted outside clustered mode");

	a_retry_reissue: assert property (
		txn.valid && txn.local_phys_region && txn.tag_unexpected &&
		txn.kind == PESL_TXN_READ_OWN
		|=> retry_issue_valid && retry_issue_kind == PESL_TXN_R_READ_OWN ##1
		(retry_issue_valid == $past(retry_req)))
		else $error("retry not reissued in remote form");

	a_no_remote_retry: assert property (
		!(txn.valid && txn.local_phys_region) |=> !retry_issue_valid)
		else $error("retry raised outside local region");

	a_snoop_cnt: assert property (
		sys_ev.remote_snoop && lower_event_select_reg == `PESL_L_SNOOP && !lcnt_wr
		|=> s_lower_step)
		else $error("remote snoop not counted");

	a_flow_tick: assert property (
		lower_event_select_reg == `PESL_L_FLOW_PAUSE && !lcnt_wr
		|=> (lower_event_counter - $past(lower_event_counter)) ==
		{31'h0000_0000, $past(sys_ev.flow_pause_out && sys_ev.sys_clk_tick)})
		else $error("flow pause count wrong");

	a_owned_cnt: assert property (
		lower_event_select_reg == `PESL_L_OWNED && !lcnt_wr && sys_ev.bus_request &&
		!sys_ev.owned_in |=> $stable(lower_event_counter))
		else $error("request without owned counted");

	a_marker_both: assert property (
		marker_hit && lower_event_select_reg == `PESL_L_SW_MARKER &&
		upper_event_select_reg == `PESL_U_SW_MARKER && !lcnt_wr && !ucnt_wr
		|=> s_lower_step ##0 s_upper_step)
		else $error("marker not counted on both counters");

	a_fp_add_cnt: assert property (
		lower_event_select_reg == `PESL_L_FP_ADD && !lcnt_wr
		|=> (lower_event_counter != $past(lower_event_counter)) ==
		$past(sys_ev.fp_adder_done))
		else $error("fp adder completion count wrong");

	a_fp_mul_cnt: assert property (
		upper_event_select_reg == `PESL_U_FP_MUL && !ucnt_wr
		|=> (upper_event_counter != $past(upper_event_counter)) ==
		$past(sys_ev.fp_mult_done))
		else $error("fp multiply completion count wrong");

	a_reserved_idle: assert property (
		(lower_event_select_reg == 6'h07 || lower_event_select_reg == 6'h1C ||
		lower_event_select_reg == 6'h26) && !lcnt_wr |=> $stable(lower_event_counter))
		else $error("reserved lower code counted");

	a_paths_indep: assert property (
		loc_ev.tag_retry_event && sys_ev.fp_mult_done &&
		lower_event_select_reg == `PESL_L_TAG_RETRY &&
		upper_event_select_reg == `PESL_U_FP_MUL && !lcnt_wr && !ucnt_wr
		|=> s_lower_step ##0 s_upper_step)
		else $error("lower and upper paths interfere");

	a_four_sources: assert property (
		s_local_read ##0 !txn.tag_unexpected |-> loc_ev.local_region_miss_event &&
		!loc_ev.tag_retry_event && !loc_ev.remote_writeback_event)
		else $error("locality source decode wrong");

endmodule : pesl_top

// ==== testbench/pesl_top_tb.sv ====
`timescale 1ns/1ns
module pesl_top_tb;
	import pesl_pkg::*;

	// one table row: selects, mode, stimulus and expected increments
	typedef struct packed {
		logic [5:0] ls; // lower select
		logic [5:0] us; // upper select
		logic md; // clustered mode bit
		logic [3:0] knd; // transaction kind code, 0 means no transaction
		logic [4:0] fl; // local, block store, commit, owned-shared store, bad tag
		logic [7:0] sv; // snoop, tick, pause, request, owned, add, mul, retire
		logic [1:0] mx; // marker word, external strobes all high
		logic [2:0] ex; // lower inc, upper inc, retry pulse
	} pesl_row_t;

	// marker word built from its instruction fields, not from the design header
	localparam logic [31:0] MARK_WORD = {2'h0, 5'h00, 3'h4, 22'(20'hFC000 >> 10)};

	// clock, reset and bus master signals
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	pesl_ahb_req_t ahb_req;
	pesl_ahb_rsp_t ahb_rsp;
	// event sources
	pesl_txn_t txn = '0;
	pesl_sys_ev_t sys_ev = '0;
	logic [63:0] ext_l = 64'h0;
	logic [63:0] ext_u = 64'h0;
	// design outputs
	logic retry_issue_valid;
	pesl_txn_kind_t retry_issue_kind;
	logic [31:0] lower_event_counter;
	logic [31:0] upper_event_counter;
	// bookkeeping
	int n_errors = 0;
	int n_checks = 0;
	logic [31:0] rd;
	pesl_row_t r;

	// ordinary cases, one row each
	pesl_row_t rows [] = '{
		'{6'h1A, 6'h28, 1'b1, 4'h1, 5'h10, 8'h00, 2'h0, 3'b100},
		'{6'h1A, 6'h28, 1'b1, 4'h2, 5'h11, 8'h00, 2'h0, 3'b111},
		'{6'h1B, 6'h29, 1'b1, 4'h3, 5'h11, 8'h00, 2'h0, 3'b101},
		'{6'h1B, 6'h28, 1'b1, 4'h1, 5'h01, 8'h00, 2'h0, 3'b000},
		'{6'h1A, 6'h29, 1'b1, 4'h4, 5'h00, 8'h00, 2'h0, 3'b010},
		'{6'h19, 6'h29, 1'b1, 4'h7, 5'h18, 8'h00, 2'h0, 3'b010},
		'{6'h19, 6'h29, 1'b1, 4'h7, 5'h04, 8'h00, 2'h0, 3'b010},
		'{6'h19, 6'h29, 1'b1, 4'h5, 5'h12, 8'h00, 2'h0, 3'b010},
		'{6'h19, 6'h29, 1'b1, 4'h5, 5'h10, 8'h00, 2'h0, 3'b000},
		'{6'h19, 6'h28, 1'b1, 4'h8, 5'h00, 8'h00, 2'h0, 3'b100},
		'{6'h19, 6'h29, 1'b1, 4'h8, 5'h10, 8'h00, 2'h0, 3'b000},
		'{6'h1A, 6'h28, 1'b0, 4'h2, 5'h11, 8'h00, 2'h0, 3'b001},
		'{6'h11, 6'h27, 1'b0, 4'h0, 5'h00, 8'h82, 2'h0, 3'b110},
		'{6'h12, 6'h1C, 1'b0, 4'h0, 5'h00, 8'h60, 2'h0, 3'b100},
		'{6'h12, 6'h27, 1'b0, 4'h0, 5'h00, 8'h20, 2'h0, 3'b000},
		'{6'h13, 6'h28, 1'b0, 4'h0, 5'h00, 8'h18, 2'h0, 3'b100},
		'{6'h13, 6'h28, 1'b0, 4'h0, 5'h00, 8'h08, 2'h0, 3'b000},
		'{6'h14, 6'h1C, 1'b0, 4'h0, 5'h00, 8'h01, 2'h2, 3'b110},
		'{6'h14, 6'h1C, 1'b0, 4'h0, 5'h00, 8'h01, 2'h0, 3'b000},
		'{6'h18, 6'h27, 1'b0, 4'h0, 5'h00, 8'h04, 2'h0, 3'b100},
		'{6'h07, 6'h17, 1'b0, 4'h0, 5'h00, 8'hFF, 2'h1, 3'b000},
		'{6'h1C, 6'h2A, 1'b1, 4'h2, 5'h11, 8'hFF, 2'h3, 3'b001},
		'{6'h3F, 6'h3F, 1'b0, 4'h0, 5'h00, 8'hFF, 2'h3, 3'b000}
	};

	// hready is looped back from the only slave
	assign ahb_req = {hsel, haddr, htrans, hwrite, hsize, hwdata, ahb_rsp.hreadyout};

	pesl_top u_pesl_top (
		.sys_clk(sys_clk),
		.reset(reset),
		.ahb_req(ahb_req),
		.ahb_rsp(ahb_rsp),
		.txn(txn),
		.sys_ev(sys_ev),
		.ext_lower_events(ext_l),
		.ext_upper_events(ext_u),
		.retry_issue_valid(retry_issue_valid),
		.retry_issue_kind(retry_issue_kind),
		.lower_event_counter(lower_event_counter),
		.upper_event_counter(upper_event_counter)
	);

	// 100 ns period
	always #50 sys_clk = ~sys_clk;

	// one comparison, counted; unknowns never match
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// wait for hready high at an edge, bounded so a stuck slave is caught
	task automatic wait_rdy;
		int k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (ahb_rsp.hreadyout !== 1'b1 && k < 100);
		chk("hready", 32'h1, {31'h0, ahb_rsp.hreadyout});
	endtask : wait_rdy

	// address phase held until accepted
	task automatic bus_addr(logic [31:0] a, logic w);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
	endtask : bus_addr

	task automatic bus_write(logic [31:0] a, logic [31:0] d);
		bus_addr(a, 1'b1);
		hwdata <= d;
		wait_rdy();
	endtask : bus_write

	// read data taken at the edge that ends the data phase
	task automatic bus_read(logic [31:0] a, output logic [31:0] d);
		bus_addr(a, 1'b0);
		wait_rdy();
		d = ahb_rsp.hrdata;
		chk("hresp", 32'h0, {31'h0, ahb_rsp.hresp});
	endtask : bus_read

	// present one row's events for exactly one cycle
	task automatic fire(pesl_row_t x);
		txn <= {(x.knd != 4'h0), x.fl[4], pesl_txn_kind_t'(x.knd), x.fl[3:0]};
		sys_ev <= {x.sv, x.mx[1] ? MARK_WORD : MARK_WORD ^ 32'h1};
		ext_l <= {64{x.mx[0]}};
		ext_u <= {64{x.mx[0]}};
		@(posedge sys_clk);
		txn <= '0;
		sys_ev <= '0;
		ext_l <= 64'h0;
		ext_u <= 64'h0;
		#1;
	endtask : fire

	task summarize;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize

	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge sys_clk);
		chk("watchdog", 32'h0, 32'h1);
		summarize();
	end

	// main sequence
	initial begin
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		#1;
		// table: fresh selects and cleared counters per row, then one event cycle
		foreach (rows[i]) begin
			r = rows[i];
			bus_write(32'h00, {15'h0, r.md, 2'h0, r.us, 2'h0, r.ls});
			bus_write(32'h04, 32'h0);
			bus_write(32'h08, 32'h0);
			fire(r);
			chk("lower", {31'h0, r.ex[2]}, lower_event_counter);
			chk("upper", {31'h0, r.ex[1]}, upper_event_counter);
			chk("retry", {31'h0, r.ex[0]}, {31'h0, retry_issue_valid});
			chk("kind", r.ex[0] ? {28'h0, r.knd + 4'h3} : 32'h0, {28'h0, retry_issue_kind});
			$display("row %0d done", i);
		end
		// control fields mask, unmapped offset reads zero
		bus_write(32'h00, 32'hFFFF_FFFF);
		bus_read(32'h00, rd);
		chk("ctrl", 32'h0001_3F3F, rd);
		bus_write(32'h0C, 32'hFFFF_FFFF);
		bus_read(32'h0C, rd);
		chk("unmapped", 32'h0, rd);
		$display("register test done");
		// wrap at full scale, one per cycle on held strobes, both counters at once
		bus_write(32'h00, 32'h0000_2718);
		bus_write(32'h04, 32'hFFFF_FFFF);
		bus_write(32'h08, 32'h0000_0007);
		sys_ev <= {8'h06, 32'h0};
		repeat (2) @(posedge sys_clk);
		sys_ev <= {8'h04, 32'h0};
		@(posedge sys_clk);
		sys_ev <= '0;
		#1;
		chk("lower", 32'h2, lower_event_counter);
		chk("upper", 32'h9, upper_event_counter);
		bus_read(32'h04, rd);
		chk("lower read", 32'h2, rd);
		$display("wrap test done");
		// back-to-back retried reads, both locality counters see both
		bus_write(32'h00, 32'h0001_281A);
		bus_write(32'h04, 32'h0);
		bus_write(32'h08, 32'h0);
		txn <= {1'b1, 1'b1, PESL_TXN_READ_SHARE, 4'h1};
		@(posedge sys_clk);
		txn <= {1'b1, 1'b1, PESL_TXN_READ_OWN, 4'h1};
		#1;
		chk("kind", 32'(PESL_TXN_R_READ_SHARE), {28'h0, retry_issue_kind});
		@(posedge sys_clk);
		txn <= '0;
		#1;
		chk("retry", 32'h1, {31'h0, retry_issue_valid});
		chk("kind", 32'(PESL_TXN_R_READ_OWN), {28'h0, retry_issue_kind});
		@(posedge sys_clk);
		#1;
		chk("retry", 32'h0, {31'h0, retry_issue_valid});
		chk("lower", 32'h2, lower_event_counter);
		chk("upper", 32'h2, upper_event_counter);
		$display("retry test done");
		// second reset in mid-run clears counters and control
		@(posedge sys_clk);
		reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		#1;
		chk("lower", 32'h0, lower_event_counter);
		chk("upper", 32'h0, upper_event_counter);
		chk("hrdata", 32'h0, ahb_rsp.hrdata);
		bus_read(32'h00, rd);
		chk("ctrl", 32'h0, rd);
		$display("reset test done");
		summarize();
	end

endmodule : pesl_top_tb
